// [eth_regs_pkg.sv]
// Register map, field layout and reset values of the host control register bank
package eth_regs_pkg;

	// ***************************************************************
	// Register byte offsets
	// ***************************************************************
	localparam logic [7:0] IRQ_ENABLE_OFF = 8'h5C;
	localparam logic [7:0] BYTE_TEST_OFF = 8'h64;
	localparam logic [7:0] LEVEL_THR_OFF = 8'h68;
	localparam logic [7:0] RX_CONFIG_OFF = 8'h6C;
	localparam logic [7:0] IRQ_STATUS_OFF = 8'h80;
	localparam logic [7:0] IRQ_CLEAR_OFF = 8'h84;

	// ***************************************************************
	// Reset values and fixed patterns
	// ***************************************************************
	localparam logic [31:0] IRQ_ENABLE_RST = 32'h00000000;
	localparam logic [31:0] LEVEL_THR_RST = 32'h48000000;
	localparam logic [31:0] RX_CONFIG_RST = 32'h00000000;
	localparam logic [31:0] BYTE_TEST_VAL = 32'h87654321;

	// Implemented enable and status bits; all other positions read zero
	localparam logic [31:0] IRQ_VALID_MASK = 32'h83BFE7DF;
	// Writable bits of the threshold word; the reserved byte reads zero
	localparam logic [31:0] LEVEL_THR_MASK = 32'hFFFF00FF;

	// ***************************************************************
	// Interrupt source positions driven from inside the bank
	// ***************************************************************
	localparam int RX_DMA_IRQ_BIT = 20;
	localparam int TX_SPACE_IRQ_BIT = 9;
	localparam int TX_STAT_LEVEL_IRQ_BIT = 7;
	localparam int RX_STAT_LEVEL_IRQ_BIT = 3;

	// ***************************************************************
	// Field positions and widths
	// ***************************************************************
	localparam int LVL_W = 8;
	localparam int TX_SPACE_LVL_LSB = 24;
	localparam int TX_STAT_LVL_LSB = 16;
	localparam int RX_STAT_LVL_LSB = 0;
	localparam int ALIGN_W = 2;
	localparam int END_ALIGN_LSB = 30;
	localparam int DMA_CNT_W = 12;
	localparam int DMA_CNT_LSB = 16;
	localparam int FLUSH_BIT = 15;
	localparam int OFFSET_W = 5;
	localparam int OFFSET_LSB = 8;

	// ***************************************************************
	// End alignment codes and the matching word pad masks
	// ***************************************************************
	localparam logic [1:0] ALIGN_4 = 2'h0;
	localparam logic [1:0] ALIGN_16 = 2'h1;
	localparam logic [1:0] ALIGN_32 = 2'h2;
	localparam logic [2:0] PAD_MASK_4 = 3'h0;
	localparam logic [2:0] PAD_MASK_16 = 3'h3;
	localparam logic [2:0] PAD_MASK_32 = 3'h7;

endpackage : eth_regs_pkg

// [level_compare.sv]
// Threshold comparator that pulses once when a FIFO level climbs above its limit
`timescale 1ns/1ps
module level_compare #(
	parameter int W = 8
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	input wire logic [W-1:0] level_in,
	input wire logic [W-1:0] thresh_in,
	output logic event_out
);

	logic above_r;
	logic above_nxt;

	assign above_nxt = (level_in > thresh_in);

	// Edge of the comparison, so a cleared flag is not re-set every cycle
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			above_r <= 1'b0;
			event_out <= 1'b0;
		end else if (clk_en_in) begin
			above_r <= above_nxt;
			event_out <= above_nxt && !above_r;
		end
	end

	AST_LEVEL_EDGE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(clk_en_in && above_nxt && !above_r) |=> event_out)
		else $error("level crossing did not raise its event");

endmodule : level_compare

// [rx_countdown.sv]
// Receive transfer countdown that flags when the programmed word count is drained
`timescale 1ns/1ps
module rx_countdown (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	input wire logic load_in,
	input wire logic [eth_regs_pkg::DMA_CNT_W-1:0] load_val_in,
	input wire logic word_read_in,
	output logic [eth_regs_pkg::DMA_CNT_W-1:0] count_out,
	output logic done_out
);

	import eth_regs_pkg::*;

	localparam logic [DMA_CNT_W-1:0] ONE = 12'h001;

	// A host load replaces the running count, even mid-transfer
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count_out <= '0;
			done_out <= 1'b0;
		end else if (clk_en_in) begin
			done_out <= 1'b0;
			if (load_in) begin
				count_out <= load_val_in;
			end else if (word_read_in && count_out != '0) begin
				count_out <= count_out - ONE;
				done_out <= (count_out == ONE);
			end
		end
	end

	AST_DMA_DONE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(clk_en_in && word_read_in && !load_in && count_out == ONE) |=> (done_out && count_out == '0))
		else $error("countdown reached zero without its event");

	AST_DMA_LOAD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(clk_en_in && load_in) |=> (count_out == $past(load_val_in) && !done_out))
		else $error("host load did not replace the running count");

endmodule : rx_countdown

// [eth_host_regs.sv]
// Host control register bank: interrupt enables, FIFO thresholds, receive configuration
`timescale 1ns/1ps

// Summary of operation
// - An enable bit at one lets its status source drive the interrupt output.
// - Status bits record events whatever the enables; masking only gates the output.
// - Software, TX stopped, RX stopped, drop half enables at 31, 25, 24, 23.
// - Enables 21 to 13: TX done, RX DMA, timer, PHY, power, overflow, errors.
// - Enables 10:6, 4:3, 2:0 for FIFO and pin sources; gaps read zero.
// - Byte order test word is read-only and always returns the fixed pattern.
// - TX space interrupt when free space in 64-byte blocks exceeds bits 31-24.
// - TX status level interrupt when used words exceed bits 23-16, reset zero.
// - RX status level interrupt when used words exceed bits 7-0; 15-8 reserved.
// - End alignment code in bits 31:30 selects 4, 16 or 32-byte word padding.
// - Transfer countdown in bits 27-16 drops per word read, flags at zero.
// - A host write to the countdown replaces the running count immediately.
// - Writing one to bit 15 flushes receive data and status pointers, self-clears.
// - Start offset in bits 12-8 inserts 0 to 31 bytes ahead of packet data.
// - Upper three offset bits may change while running, applied at next word read.
module eth_host_regs (
	input wire logic CORE_CLK_IN,
	input wire logic RST_N_IN,
	input wire logic CLK_EN_IN,
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_WE_IN,
	input wire logic [7:0] WB_ADR_IN,
	input wire logic [3:0] WB_SEL_IN,
	input wire logic [31:0] WB_DAT_IN,
	output logic [31:0] WB_DAT_OUT,
	output logic WB_ACK_OUT,
	input wire logic [31:0] SRC_EVENT_IN,
	input wire logic [eth_regs_pkg::LVL_W-1:0] TX_DATA_FREE_IN,
	input wire logic [eth_regs_pkg::LVL_W-1:0] TX_STAT_USED_IN,
	input wire logic [eth_regs_pkg::LVL_W-1:0] RX_STAT_USED_IN,
	input wire logic RX_WORD_READ_IN,
	output logic IRQ_OUT,
	output logic RX_FLUSH_OUT,
	output logic [eth_regs_pkg::ALIGN_W-1:0] RX_END_ALIGN_OUT,
	output logic [2:0] RX_PAD_MASK_OUT,
	output logic [eth_regs_pkg::OFFSET_W-1:0] RX_START_OFFSET_OUT
);

	import eth_regs_pkg::*;

	// ***************************************************************
	// Declarations
	// ***************************************************************
	logic [31:0] ien_r;
	logic [31:0] thr_r;
	logic [31:0] sts_r;
	logic [31:0] sts_nxt;
	logic [31:0] set_vec;
	logic [31:0] clr_vec;
	logic [ALIGN_W-1:0] align_r;
	logic [OFFSET_W-1:0] off_req_r;
	logic [DMA_CNT_W-1:0] dma_count;
	logic dma_done;
	logic tx_space_evt;
	logic tx_stat_evt;
	logic rx_stat_evt;
	logic req;
	logic wr_en;
	logic [7:0] word_adr;
	logic [31:0] wr_ien;
	logic [31:0] wr_thr;
	logic [31:0] wr_cfg;
	logic [31:0] cfg_rd;
	logic [31:0] rd_nxt;
	logic [2:0] pad_nxt;
	logic dma_load;
	logic irq_nxt;

	// Byte-lane merge of write data into the current value
	function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] wd,
		input logic [3:0] sel);
		logic [31:0] res;
		res = cur;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	// ***************************************************************
	// Wishbone slave
	// ***************************************************************

	// Writes land on the edge the master samples ack, never earlier
	assign req = WB_CYC_IN && WB_STB_IN;
	assign word_adr = {WB_ADR_IN[7:2], 2'b00};
	assign wr_en = req && WB_WE_IN && WB_ACK_OUT;

	// Single-wait acknowledge, dropped in the cycle after it was given
	always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			WB_ACK_OUT <= 1'b0;
		end else if (CLK_EN_IN) begin
			WB_ACK_OUT <= req && !WB_ACK_OUT;
		end
	end

	// Receive configuration as read back; flush bit always reads zero
	always_comb begin
		cfg_rd = 32'h00000000;
		cfg_rd[END_ALIGN_LSB +: ALIGN_W] = align_r;
		cfg_rd[DMA_CNT_LSB +: DMA_CNT_W] = dma_count;
		cfg_rd[OFFSET_LSB +: OFFSET_W] = off_req_r;
	end

	// Read mux; unmapped and write-only offsets return zero
	always_comb begin
		unique case (word_adr)
			IRQ_ENABLE_OFF: rd_nxt = ien_r;
			BYTE_TEST_OFF: rd_nxt = BYTE_TEST_VAL;
			LEVEL_THR_OFF: rd_nxt = thr_r;
			RX_CONFIG_OFF: rd_nxt = cfg_rd;
			IRQ_STATUS_OFF: rd_nxt = sts_r;
			default: rd_nxt = 32'h00000000;
		endcase
	end

	// Read data captured as ack rises, held until the next read
	always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			WB_DAT_OUT <= 32'h00000000;
		end else if (CLK_EN_IN && req && !WB_ACK_OUT && !WB_WE_IN) begin
			WB_DAT_OUT <= rd_nxt;
		end
	end

	// ***************************************************************
	// Interrupt enable and threshold registers
	// ***************************************************************
	assign wr_ien = merge(ien_r, WB_DAT_IN, WB_SEL_IN) & IRQ_VALID_MASK;
	assign wr_thr = merge(thr_r, WB_DAT_IN, WB_SEL_IN) & LEVEL_THR_MASK;

	// Enable mask; reserved positions can never be set
	always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			ien_r <= IRQ_ENABLE_RST;
		end else if (CLK_EN_IN && wr_en && word_adr == IRQ_ENABLE_OFF) begin
			ien_r <= wr_ien;
		end
	end

	// FIFO level thresholds
	always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			thr_r <= LEVEL_THR_RST;
		end else if (CLK_EN_IN && wr_en && word_adr == LEVEL_THR_OFF) begin
			thr_r <= wr_thr;
		end
	end

	// ***************************************************************
	// Level comparators
	// ***************************************************************
	level_compare #(.W(LVL_W)) u_tx_space (
		.clk_in(CORE_CLK_IN),
		.rst_n_in(RST_N_IN),
		.clk_en_in(CLK_EN_IN),
		.level_in(TX_DATA_FREE_IN),
		.thresh_in(thr_r[TX_SPACE_LVL_LSB +: LVL_W]),
		.event_out(tx_space_evt)
	);

	level_compare #(.W(LVL_W)) u_tx_stat (
		.clk_in(CORE_CLK_IN),
		.rst_n_in(RST_N_IN),
		.clk_en_in(CLK_EN_IN),
		.level_in(TX_STAT_USED_IN),
		.thresh_in(thr_r[TX_STAT_LVL_LSB +: LVL_W]),
		.event_out(tx_stat_evt)
	);

	level_compare #(.W(LVL_W)) u_rx_stat (
		.clk_in(CORE_CLK_IN),
		.rst_n_in(RST_N_IN),
		.clk_en_in(CLK_EN_IN),
		.level_in(RX_STAT_USED_IN),
		.thresh_in(thr_r[RX_STAT_LVL_LSB +: LVL_W]),
		.event_out(rx_stat_evt)
	);

	// ***************************************************************
	// Receive configuration
	// ***************************************************************
	assign wr_cfg = merge(cfg_rd, WB_DAT_IN, WB_SEL_IN);
	assign dma_load = wr_en && word_adr == RX_CONFIG_OFF && (WB_SEL_IN[2] || WB_SEL_IN[3]);

	// Alignment is taken as written; the host keeps it stable mid-packet
	always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			align_r <= RX_CONFIG_RST[END_ALIGN_LSB +: ALIGN_W];
			off_req_r <= RX_CONFIG_RST[OFFSET_LSB +: OFFSET_W];
		end else if (CLK_EN_IN && wr_en && word_adr == RX_CONFIG_OFF) begin
			align_r <= wr_cfg[END_ALIGN_LSB +: ALIGN_W];
			off_req_r <= wr_cfg[OFFSET_LSB +: OFFSET_W];
		end
	end

	// Word pad mask for the datapath; reserved code falls back to no padding
	always_comb begin
		unique case (align_r)
			ALIGN_16: pad_nxt = PAD_MASK_16;
			ALIGN_32: pad_nxt = PAD_MASK_32;
			default: pad_nxt = PAD_MASK_4;
		endcase
	end

	// Registered alignment outputs; padding words are the host's to drop
	always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			RX_END_ALIGN_OUT <= RX_CONFIG_RST[END_ALIGN_LSB +: ALIGN_W];
			RX_PAD_MASK_OUT <= PAD_MASK_4;
		end else if (CLK_EN_IN) begin
			RX_END_ALIGN_OUT <= align_r;
			RX_PAD_MASK_OUT <= pad_nxt;
		end
	end

	// Word part of the offset waits for a word read; byte part follows at once
	always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			RX_START_OFFSET_OUT <= RX_CONFIG_RST[OFFSET_LSB +: OFFSET_W];
		end else if (CLK_EN_IN) begin
			RX_START_OFFSET_OUT[1:0] <= off_req_r[1:0];
			if (RX_WORD_READ_IN) begin
				RX_START_OFFSET_OUT[4:2] <= off_req_r[4:2];
			end
		end
	end

	// Flush strobe lasts one enabled cycle, so the bit never reads back set
	always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			RX_FLUSH_OUT <= 1'b0;
		end else if (CLK_EN_IN) begin
			RX_FLUSH_OUT <= wr_en && word_adr == RX_CONFIG_OFF && wr_cfg[FLUSH_BIT];
		end
	end

	rx_countdown u_countdown (
		.clk_in(CORE_CLK_IN),
		.rst_n_in(RST_N_IN),
		.clk_en_in(CLK_EN_IN),
		.load_in(dma_load),
		.load_val_in(wr_cfg[DMA_CNT_LSB +: DMA_CNT_W]),
		.word_read_in(RX_WORD_READ_IN),
		.count_out(dma_count),
		.done_out(dma_done)
	);

	// ***************************************************************
	// Interrupt status and output
	// ***************************************************************

	// Internal events replace the matching external lines
	always_comb begin
		set_vec = SRC_EVENT_IN;
		set_vec[RX_DMA_IRQ_BIT] = dma_done;
		set_vec[TX_SPACE_IRQ_BIT] = tx_space_evt;
		set_vec[TX_STAT_LEVEL_IRQ_BIT] = tx_stat_evt;
		set_vec[RX_STAT_LEVEL_IRQ_BIT] = rx_stat_evt;
		set_vec = set_vec & IRQ_VALID_MASK;
	end

	// Write-one-to-clear through its own offset
	assign clr_vec = (wr_en && word_adr == IRQ_CLEAR_OFF) ?
		merge(32'h00000000, WB_DAT_IN, WB_SEL_IN) : 32'h00000000;

	// Set beats clear so an event in the clearing cycle is kept
	assign sts_nxt = (sts_r & ~clr_vec) | set_vec;

	// Status ignores the enables entirely
	always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			sts_r <= 32'h00000000;
		end else if (CLK_EN_IN) begin
			sts_r <= sts_nxt;
		end
	end

	assign irq_nxt = |(sts_r & ien_r);

	// Registered level output, one cycle behind the status
	always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			IRQ_OUT <= 1'b0;
		end else if (CLK_EN_IN) begin
			IRQ_OUT <= irq_nxt;
		end
	end

	// ***************************************************************
	// Assertions
	// ***************************************************************
	AST_IRQ_GATE: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
		$past(CLK_EN_IN) |-> (IRQ_OUT == |($past(sts_r) & $past(ien_r))))
		else $error("interrupt output differs from gated status");

	AST_IRQ_MASKED: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
		(CLK_EN_IN && ien_r == 32'h00000000) |=> !IRQ_OUT)
		else $error("interrupt raised with every source disabled");

	AST_STS_RECORD: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
		CLK_EN_IN |=> ((sts_r & $past(set_vec)) == $past(set_vec)))
		else $error("event lost from status");

	AST_IEN_RESERVED: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
		(CLK_EN_IN && wr_en && word_adr == IRQ_ENABLE_OFF)
		|=> (ien_r == (merge($past(ien_r), $past(WB_DAT_IN), $past(WB_SEL_IN)) & 32'h83BFE7DF)))
		else $error("enable write stored wrong bits");

	AST_BYTE_TEST: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
		($rose(WB_ACK_OUT) && $past(word_adr == BYTE_TEST_OFF && !WB_WE_IN))
		|-> (WB_DAT_OUT == 32'h87654321))
		else $error("byte order test word read back wrong");

	AST_FLUSH_ONCE: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
		(RX_FLUSH_OUT && CLK_EN_IN) |=> (!RX_FLUSH_OUT && cfg_rd[FLUSH_BIT] == 1'b0))
		else $error("flush strobe did not clear itself");

	AST_OFFSET_WORD: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
		(CLK_EN_IN && RX_WORD_READ_IN) |=> (RX_START_OFFSET_OUT[4:2] == $past(off_req_r[4:2])))
		else $error("word offset not applied at word read");

	AST_OFFSET_HOLD: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
		(CLK_EN_IN && !RX_WORD_READ_IN) |=> $stable(RX_START_OFFSET_OUT[4:2]))
		else $error("word offset changed without a word read");

	AST_PAD_MASK: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
		(CLK_EN_IN && align_r == 2'h2) |=> (RX_PAD_MASK_OUT == 3'h7))
		else $error("32-byte alignment gave wrong pad mask");

	AST_SET_WINS: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
		(CLK_EN_IN && |(set_vec & clr_vec)) |=> |(sts_r & $past(set_vec & clr_vec)))
		else $error("clear beat a simultaneous event");

endmodule : eth_host_regs

// [rx_fifo_env.sv]
// Model of the receive FIFO side: paced word reads and a flush pulse counter
`timescale 1ns/1ps
module rx_fifo_env (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic load_in,
	input wire logic [7:0] words_in,
	input wire logic flush_in,
	output logic word_read_out,
	output logic busy_out,
	output logic [7:0] flush_count_out
);
	logic [7:0] left_r;

	// ***************************************************************
	// Word read pacing
	// ***************************************************************
	// One read every other cycle, so back-to-back reads never hide a missed decrement
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			left_r <= 8'h00;
			word_read_out <= 1'b0;
		end else if (load_in) begin
			left_r <= words_in;
			word_read_out <= 1'b0;
		end else if (left_r != 8'h00 && !word_read_out) begin
			left_r <= left_r - 8'h01;
			word_read_out <= 1'b1;
		end else begin
			word_read_out <= 1'b0;
		end
	end
	assign busy_out = (left_r != 8'h00) || word_read_out;

	// Count flush pulses, one per cycle high
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			flush_count_out <= 8'h00;
		end else if (flush_in) begin
			flush_count_out <= flush_count_out + 8'h01;
		end
	end
endmodule : rx_fifo_env

// [test_eth_host_regs.sv]
// Self-checking bench for the host control register bank
`timescale 1ns/1ps
module test_eth_host_regs;
	import eth_regs_pkg::*;
	logic clk, rst_n, cyc, stb, we, ack, irq, flush, wrd, busy, ld;
	logic [7:0] adr, words, fcnt, txf, txs, rxs;
	logic [3:0] sel;
	logic [31:0] dat_w, dat_r, evt, rd;
	logic [1:0] align;
	logic [2:0] pad;
	logic [4:0] offs;
	int n_fail = 0;
	int check_count = 0;
	int cycles = 0;

	// ***************************************************************
	// Clock, reset and instances
	// ***************************************************************
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	eth_host_regs u_eth_host_regs (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .CLK_EN_IN(1'b1),
		.WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel),
		.WB_DAT_IN(dat_w), .WB_DAT_OUT(dat_r), .WB_ACK_OUT(ack), .SRC_EVENT_IN(evt),
		.TX_DATA_FREE_IN(txf), .TX_STAT_USED_IN(txs), .RX_STAT_USED_IN(rxs),
		.RX_WORD_READ_IN(wrd), .IRQ_OUT(irq), .RX_FLUSH_OUT(flush), .RX_END_ALIGN_OUT(align),
		.RX_PAD_MASK_OUT(pad), .RX_START_OFFSET_OUT(offs));
	rx_fifo_env u_rx_fifo_env (.clk_in(clk), .rst_n_in(rst_n), .load_in(ld), .words_in(words),
		.flush_in(flush), .word_read_out(wrd), .busy_out(busy), .flush_count_out(fcnt));

	// ***************************************************************
	// Bus and check tasks
	// ***************************************************************
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	// Classic single cycle: hold everything until ack is sampled high
	task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s = 4'hF);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		dat_w <= d;
		do @(posedge clk); while (ack !== 1'b1);
		rd = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask : wb_cycle

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		wb_cycle(1'b0, a, 32'h00000000);
		check(rd, exp);
	endtask : rd_chk

	// Ask the FIFO side model for n word reads and wait until they are done
	task automatic reads(input logic [7:0] n);
		int k;
		ld <= 1'b1;
		words <= n;
		@(posedge clk);
		ld <= 1'b0;
		for (k = 0; k < 100 && (busy !== 1'b0 || k < 2); k++) @(posedge clk);
		tick(3);
	endtask : reads

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : conclude

	// Cut a hang short well beyond the expected run length
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_fail++;
			conclude();
		end
	end

	// ***************************************************************
	// Test sequence
	// ***************************************************************
	initial begin
		logic [2:0] pads [4];
		pads = '{PAD_MASK_4, PAD_MASK_16, PAD_MASK_32, PAD_MASK_4};
		{rst_n, cyc, stb, we, ld} <= 5'b00000;
		{adr, words, txf, txs, rxs, sel} <= '0;
		{dat_w, evt} <= '0;
		tick(6);
		rst_n <= 1'b1;
		tick(2);
		// Reset values and read-only words
		rd_chk(IRQ_ENABLE_OFF, 32'h00000000);
		rd_chk(BYTE_TEST_OFF, 32'h87654321);
		rd_chk(LEVEL_THR_OFF, 32'h48000000);
		rd_chk(RX_CONFIG_OFF, 32'h00000000);
		wb_cycle(1'b1, IRQ_ENABLE_OFF, 32'hFFFFFFFF);
		rd_chk(IRQ_ENABLE_OFF, 32'h83BFE7DF);
		wb_cycle(1'b1, BYTE_TEST_OFF, 32'h00000000);
		rd_chk(BYTE_TEST_OFF, 32'h87654321);
		wb_cycle(1'b1, LEVEL_THR_OFF, 32'hFFFFFFFF);
		rd_chk(LEVEL_THR_OFF, 32'hFFFF00FF);
		rd_chk(8'h40, 32'h00000000);
		$display("test registers done");
		// Masked event still recorded, then unmasked onto the output
		wb_cycle(1'b1, IRQ_ENABLE_OFF, 32'h00000000);
		evt <= 32'h80000000;
		@(posedge clk);
		evt <= 32'h00000000;
		tick(3);
		check(irq, 1'b0);
		rd_chk(IRQ_STATUS_OFF, 32'h80000000);
		wb_cycle(1'b1, IRQ_ENABLE_OFF, 32'h80000000);
		tick(2);
		check(irq, 1'b1);
		wb_cycle(1'b1, IRQ_CLEAR_OFF, 32'hFFFFFFFF);
		tick(2);
		check(irq, 1'b0);
		// Event pulse on the very edge the clear lands: the event must survive
		fork
			wb_cycle(1'b1, IRQ_CLEAR_OFF, 32'h00000001);
			begin
				tick(1);
				evt <= 32'h00000001;
				tick(1);
				evt <= 32'h00000000;
			end
		join
		rd_chk(IRQ_STATUS_OFF, 32'h00000001);
		wb_cycle(1'b1, IRQ_CLEAR_OFF, 32'h00000001);
		rd_chk(IRQ_STATUS_OFF, 32'h00000000);
		$display("test interrupt done");
		// Levels climbing above programmed thresholds
		wb_cycle(1'b1, LEVEL_THR_OFF, 32'h10050002);
		txf <= 8'h20;
		txs <= 8'h06;
		rxs <= 8'h03;
		tick(4);
		rd_chk(IRQ_STATUS_OFF, 32'h00000288);
		check(irq, 1'b0);
		wb_cycle(1'b1, IRQ_CLEAR_OFF, 32'hFFFFFFFF);
		$display("test thresholds done");
		// Countdown, overwritten before it drains
		wb_cycle(1'b1, RX_CONFIG_OFF, 32'h00030000);
		rd_chk(RX_CONFIG_OFF, 32'h00030000);
		reads(8'h02);
		rd_chk(RX_CONFIG_OFF, 32'h00010000);
		wb_cycle(1'b1, RX_CONFIG_OFF, 32'h00020000);
		rd_chk(RX_CONFIG_OFF, 32'h00020000);
		reads(8'h02);
		rd_chk(IRQ_STATUS_OFF, 32'h00100000);
		// A write that leaves the count lanes out keeps the running count
		wb_cycle(1'b1, RX_CONFIG_OFF, 32'h00050000);
		wb_cycle(1'b1, RX_CONFIG_OFF, 32'hFFFF1FFF, 4'h2);
		rd_chk(RX_CONFIG_OFF, 32'h00051F00);
		$display("test countdown done");
		// Offset: low bits follow the register, word offset waits for a read
		wb_cycle(1'b1, RX_CONFIG_OFF, 32'h00001F00);
		tick(3);
		check(32'(offs), 32'h00000003);
		reads(8'h01);
		check(32'(offs), 32'h0000001F);
		// Flush pulse and self-clearing bit
		wb_cycle(1'b1, RX_CONFIG_OFF, 32'h00008000);
		tick(3);
		check(32'(fcnt), 32'h00000001);
		rd_chk(RX_CONFIG_OFF, 32'h00000000);
		$display("test offset and flush done");
		// Every end alignment code, set between packets
		for (int i = 0; i < 4; i++) begin
			wb_cycle(1'b1, RX_CONFIG_OFF, {2'(i), 30'h0});
			tick(2);
			check(32'(align), 32'(i));
			check(32'(pad), 32'(pads[i]));
		end
		$display("test alignment done");
		// Reset in mid-run brings the registers back to their defaults
		rst_n <= 1'b0;
		tick(2);
		rst_n <= 1'b1;
		tick(2);
		rd_chk(LEVEL_THR_OFF, 32'h48000000);
		rd_chk(IRQ_ENABLE_OFF, 32'h00000000);
		check(32'(align), 32'h00000000);
		$display("test reset done");
		conclude();
	end
endmodule : test_eth_host_regs
